// *** core/psm_pkg.sv ***
package psm_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned RST_STAB_US     = 64000;
  localparam int unsigned OSC_PERIOD_PS   = 250000;
  localparam int unsigned RST_OSC_PERIODS = 7;
  // Stabilisation part reckoned in ns so that the product stays inside 32 bits
  localparam int unsigned RST_WAIT_CYC    = (RST_STAB_US * 1000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000)
                                          + (RST_OSC_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PF_FILTER_NS    = 50;
  localparam int unsigned PF_FILTER_CYC   = (PF_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PRESCALE_DIV    = 2048;
  localparam int unsigned RC_TICKS_PER_WD = 256;

  // Register byte offsets
  localparam logic [7:0] OFF_CKCTL = 8'h00;
  localparam logic [7:0] OFF_IRQ_ENABLE_HIGH_REG  = 8'h04;
  localparam logic [7:0] OFF_WDTP  = 8'h08;
  localparam logic [7:0] OFF_PFCFG = 8'h0C;
  localparam logic [7:0] OFF_TIMER0_COMPARE_VALUE  = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;

  // Field positions
  localparam int unsigned CK_WAKE_BIT   = 6;
  localparam int unsigned CK_RCWD_BIT   = 5;
  localparam int unsigned CK_WDRST_BIT  = 4;
  localparam int unsigned IE_WDT_BIT    = 0;
  localparam int unsigned WP_CLR_BIT    = 7;
  localparam int unsigned PF_DIS_BIT    = 0;
  localparam int unsigned PF_MODE_BIT   = 1;
  localparam int unsigned TDR_CASC_BIT  = 16;

  // Reset values
  localparam logic [7:0]  CKCTL_RST = 8'h00;
  localparam logic [7:0]  IRQ_ENABLE_HIGH_REG_RST  = 8'h00;
  localparam logic [7:0]  WDTP_RST  = 8'h7F;
  localparam logic [7:0]  PFCFG_RST = 8'h00;
  localparam logic [16:0] TIMER0_COMPARE_VALUE_RST  = 17'h000FF;

  typedef enum logic [2:0] {
    S_RSTW = 3'h0,
    S_RUN  = 3'h1,
    S_WAKE = 3'h3,
    S_STOP = 3'h2,
    S_RCWD = 3'h6,
    S_STAB = 3'h7
  } psm_state_e;

  typedef struct packed {
    logic cpu_run;
    logic main_osc_en;
    logic prescaler_en;
    logic timer0_en;
    logic rc_osc_en;
    logic port_hold;
  } psm_gate_s;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] addr;
  } psm_aph_s;

endpackage : psm_pkg

// *** core/psm_ctrl.sv ***
// Behaviour
// - Wake-timer mode: oscillator on, only /2048 prescaler and timer0 run, state held.
// - Sleep with wake_timer_select set enters wake-timer mode.
// - Wake interval comes from timer0_compare_value, optionally 16-bit cascaded.
// - Wake-timer mode exits on reset, timer0 overflow or external interrupt.
// - Interrupt release vectors when I-flag is 1, else resumes after sleep.
// - Wake-timer exit by interrupt or overflow needs no stabilisation wait.
// - RC watchdog mode stops main oscillator, RC oscillator keeps running.
// - Sleep with select bits 01 enters RC watchdog mode.
// - RC watchdog mode exits on reset, watchdog event or external interrupt.
// - Watchdog event with I=1, reset-select 0, irq enable 1 runs watchdog handler.
// - Watchdog event with reset-select 1 makes an internal reset.
// - Exit from oscillator-stopped mode counts interval timer 00 to FF first.
// - Port pins keep their held levels in every power saving mode.
// - After reset wait 64 ms plus 7 oscillator periods before running.
// - Reset leaves RAM untouched; only control registers reinitialise.
// - Power-fail detector enabled when its config bit is clear.
// - Power-fail lasting over 50 ns resets according to the mode bit.
// - Sleep with select bits 00 enters full stop mode.
// - Sleep with any interrupt flag pending is ignored.
// - Watchdog event when counter equals low seven bits of period register.
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module psm_ctrl #(
  parameter int unsigned RST_WAIT = psm_pkg::RST_WAIT_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // CPU core
  input  wire logic              sleep_exec,
  input  wire logic              irq_pending,
  input  wire logic              i_flag,
  output logic                   resume_pulse,
  output logic                   vector_pulse,
  output logic                   wdt_vector_pulse,
  output logic                   int_reset,
  // Pins and RC oscillator
  input  wire logic              ext_int_pin,
  input  wire logic              power_fail_pin,
  input  wire logic              rc_osc_pin,
  // Clock and power gating
  output var psm_pkg::psm_gate_s gate
);

  // Synchronisers: stage one feeds stage two only
  logic [2:0] sync1_q, sync2_q;
  logic       rc_prev_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_q   <= 3'h0;
      sync2_q   <= 3'h0;
      rc_prev_q <= 1'b0;
    end else begin
      sync1_q   <= {rc_osc_pin, power_fail_pin, ext_int_pin};
      sync2_q   <= sync1_q;
      rc_prev_q <= sync2_q[2];
    end
  end
  wire logic ext_int = sync2_q[0];
  wire logic pfail   = sync2_q[1];
  wire logic rc_rise = sync2_q[2] & ~rc_prev_q;

  function automatic psm_pkg::psm_gate_s gate_of(input psm_pkg::psm_state_e s);
    psm_pkg::psm_gate_s g;
    g = '0;
    case (s)
      psm_pkg::S_RUN:  g = '{cpu_run: 1'b1, main_osc_en: 1'b1, prescaler_en: 1'b1, timer0_en: 1'b1,
                             rc_osc_en: 1'b0, port_hold: 1'b0};
      psm_pkg::S_WAKE: g = '{cpu_run: 1'b0, main_osc_en: 1'b1, prescaler_en: 1'b1, timer0_en: 1'b1,
                             rc_osc_en: 1'b0, port_hold: 1'b1};
      psm_pkg::S_RCWD: g = '{cpu_run: 1'b0, main_osc_en: 1'b0, prescaler_en: 1'b0, timer0_en: 1'b0,
                             rc_osc_en: 1'b1, port_hold: 1'b1};
      psm_pkg::S_STAB: g = '{cpu_run: 1'b0, main_osc_en: 1'b1, prescaler_en: 1'b1, timer0_en: 1'b0,
                             rc_osc_en: 1'b0, port_hold: 1'b1};
      psm_pkg::S_STOP: g = '{cpu_run: 1'b0, main_osc_en: 1'b0, prescaler_en: 1'b0, timer0_en: 1'b0,
                             rc_osc_en: 1'b0, port_hold: 1'b1};
      psm_pkg::S_RSTW: g = '{cpu_run: 1'b0, main_osc_en: 1'b1, prescaler_en: 1'b0, timer0_en: 1'b0,
                             rc_osc_en: 1'b0, port_hold: 1'b0};
      default:         g = '0;
    endcase
    return g;
  endfunction : gate_of

  // Registers and bus
  logic [7:0]        ckctl_q, ckctl_d, irq_enable_high_reg_q, irq_enable_high_reg_d, wdtp_q, wdtp_d, pfcfg_q, pfcfg_d;
  logic [16:0]       tdr_q, tdr_d;
  logic [31:0]       hrdata_d;
  logic              wd_clr_d, wd_clr_q;
  psm_pkg::psm_aph_s aph_q, aph_d;
  psm_pkg::psm_state_e st_q, st_d;
  logic              int_rst_q, int_rst_d;

  always_comb begin
    ckctl_d  = ckctl_q;
    irq_enable_high_reg_d   = irq_enable_high_reg_q;
    wdtp_d   = wdtp_q;
    pfcfg_d  = pfcfg_q;
    tdr_d    = tdr_q;
    hrdata_d = hrdata;
    wd_clr_d = 1'b0;
    aph_d.sel   = hsel & htrans[1] & hready;
    aph_d.write = hwrite;
    aph_d.addr  = haddr[7:0];
    if (aph_d.sel && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        psm_pkg::OFF_CKCTL: hrdata_d = {24'h0, ckctl_q};
        psm_pkg::OFF_IRQ_ENABLE_HIGH_REG:  hrdata_d = {24'h0, irq_enable_high_reg_q};
        psm_pkg::OFF_WDTP:  hrdata_d = {24'h0, wdtp_q};
        psm_pkg::OFF_PFCFG: hrdata_d = {24'h0, pfcfg_q};
        psm_pkg::OFF_TIMER0_COMPARE_VALUE:  hrdata_d = {15'h0, tdr_q};
        psm_pkg::OFF_STAT:  hrdata_d = {29'h0, st_q};
        default:            hrdata_d = 32'h0;
      endcase
    end
    // Whole-register writes only; byte lanes are not merged
    if (aph_q.sel && aph_q.write) begin
      case ({aph_q.addr[7:2], 2'b00})
        psm_pkg::OFF_CKCTL: ckctl_d = hwdata[7:0];
        psm_pkg::OFF_IRQ_ENABLE_HIGH_REG:  irq_enable_high_reg_d  = hwdata[7:0];
        psm_pkg::OFF_WDTP: begin
          wdtp_d   = {1'b0, hwdata[6:0]};
          wd_clr_d = hwdata[psm_pkg::WP_CLR_BIT];
        end
        psm_pkg::OFF_PFCFG: pfcfg_d = hwdata[7:0];
        psm_pkg::OFF_TIMER0_COMPARE_VALUE:  tdr_d   = hwdata[16:0];
        default: ;
      endcase
    end
  end

  // Internal resets reinitialise control registers; memory is never cleared here
  always_ff @(posedge ref_clk) begin
    if (!nrst || int_rst_q) begin
      ckctl_q   <= psm_pkg::CKCTL_RST;
      irq_enable_high_reg_q    <= psm_pkg::IRQ_ENABLE_HIGH_REG_RST;
      wdtp_q    <= psm_pkg::WDTP_RST;
      pfcfg_q   <= psm_pkg::PFCFG_RST;
      tdr_q     <= psm_pkg::TIMER0_COMPARE_VALUE_RST;
      wd_clr_q  <= 1'b0;
      aph_q     <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ckctl_q   <= ckctl_d;
      irq_enable_high_reg_q    <= irq_enable_high_reg_d;
      wdtp_q    <= wdtp_d;
      pfcfg_q   <= pfcfg_d;
      tdr_q     <= tdr_d;
      wd_clr_q  <= wd_clr_d;
      aph_q     <= aph_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Sequencer
  logic [23:0] cnt_q, cnt_d;
  logic [10:0] pre_q, pre_d;
  logic [15:0] t0_q, t0_d;
  logic [7:0]  rcdiv_q, rcdiv_d;
  logic [6:0]  wdc_q, wdc_d;
  logic [2:0]  pf_q, pf_d;
  logic [1:0]  pend_q, pend_d;
  logic        resume_d, vector_d, wdtv_d;

  wire logic [10:0] bit_mask = 11'((12'h002 << ckctl_q[2:0]) - 12'h001);
  wire logic        bit_tick = &(pre_q | ~bit_mask);
  wire logic        pre_wrap = (pre_q == 11'(psm_pkg::PRESCALE_DIV - 1));
  wire logic [15:0] t0_lim   = tdr_q[psm_pkg::TDR_CASC_BIT] ? tdr_q[15:0] : {8'h00, tdr_q[7:0]};
  wire logic        t0_ovf   = pre_wrap && (t0_q == t0_lim);
  wire logic        rc_wrap  = rc_rise && (rcdiv_q == 8'(psm_pkg::RC_TICKS_PER_WD - 1));
  wire logic        wdt_evt  = rc_wrap && (wdc_q == wdtp_q[6:0]);
  // Fires once as the filter count completes, so a long fault gives a single reset pulse
  wire logic        pf_fire  = !pfcfg_q[psm_pkg::PF_DIS_BIT] && pfcfg_q[psm_pkg::PF_MODE_BIT]
                               && pfail && (pf_q == 3'(psm_pkg::PF_FILTER_CYC - 1));

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    pre_d     = gate_q_pre_en() ? pre_q + 11'h001 : pre_q;
    t0_d      = t0_q;
    rcdiv_d   = rcdiv_q;
    wdc_d     = wd_clr_q ? 7'h00 : wdc_q;
    pend_d    = pend_q;
    resume_d  = 1'b0;
    vector_d  = 1'b0;
    wdtv_d    = 1'b0;
    int_rst_d = 1'b0;
    pf_d      = (pfail && pf_q != 3'(psm_pkg::PF_FILTER_CYC)) ? pf_q + 3'h1 : (pfail ? pf_q : 3'h0);
    case (st_q)
      psm_pkg::S_RSTW: begin
        cnt_d = cnt_q + 24'h000001;
        if (cnt_q == 24'(RST_WAIT - 1)) begin
          st_d  = psm_pkg::S_RUN;
          cnt_d = 24'h0;
        end
      end
      psm_pkg::S_RUN: begin
        if (sleep_exec && !irq_pending) begin
          pre_d = 11'h000;
          t0_d  = 16'h0000;
          if (ckctl_q[psm_pkg::CK_WAKE_BIT]) st_d = psm_pkg::S_WAKE;
          else if (ckctl_q[psm_pkg::CK_RCWD_BIT]) begin
            st_d    = psm_pkg::S_RCWD;
            rcdiv_d = 8'h00;
          end else st_d = psm_pkg::S_STOP;
        end
      end
      psm_pkg::S_WAKE: begin
        if (pre_wrap) t0_d = t0_q + 16'h0001;
        if (ext_int || t0_ovf) begin
          st_d     = psm_pkg::S_RUN;
          vector_d = i_flag;
          resume_d = !i_flag;
        end
      end
      psm_pkg::S_STOP: begin
        if (ext_int) begin
          st_d   = psm_pkg::S_STAB;
          cnt_d  = 24'h0;
          pend_d = {1'b0, i_flag};
        end
      end
      psm_pkg::S_RCWD: begin
        if (rc_rise) rcdiv_d = rcdiv_q + 8'h01;
        if (rc_wrap) wdc_d = wdc_q + 7'h01;
        if (wdt_evt && ckctl_q[psm_pkg::CK_WDRST_BIT]) begin
          int_rst_d = 1'b1;
          st_d      = psm_pkg::S_RSTW;
          cnt_d     = 24'h0;
        end else if (ext_int || wdt_evt) begin
          st_d   = psm_pkg::S_STAB;
          cnt_d  = 24'h0;
          pend_d = {wdt_evt && !ext_int && irq_enable_high_reg_q[psm_pkg::IE_WDT_BIT], i_flag};
        end
      end
      psm_pkg::S_STAB: begin
        // Ratio comes from software; too short a count gives an unsettled clock
        if (bit_tick) cnt_d = cnt_q + 24'h000001;
        if (bit_tick && cnt_q[7:0] == 8'hFF) begin
          st_d     = psm_pkg::S_RUN;
          cnt_d    = 24'h0;
          wdtv_d   = pend_q[0] && pend_q[1];
          vector_d = pend_q[0] && !pend_q[1];
          resume_d = !pend_q[0];
        end
      end
      default: st_d = psm_pkg::S_RSTW;
    endcase
    if (pf_fire) begin
      int_rst_d = 1'b1;
      st_d      = psm_pkg::S_RSTW;
      cnt_d     = 24'h0;
      resume_d  = 1'b0;
      vector_d  = 1'b0;
      wdtv_d    = 1'b0;
    end
  end

  function automatic logic gate_q_pre_en();
    return gate.prescaler_en;
  endfunction : gate_q_pre_en

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q             <= psm_pkg::S_RSTW;
      cnt_q            <= 24'h0;
      pre_q            <= 11'h000;
      t0_q             <= 16'h0000;
      rcdiv_q          <= 8'h00;
      wdc_q            <= 7'h00;
      pf_q             <= 3'h0;
      pend_q           <= 2'h0;
      resume_pulse     <= 1'b0;
      vector_pulse     <= 1'b0;
      wdt_vector_pulse <= 1'b0;
      int_rst_q        <= 1'b0;
      int_reset        <= 1'b0;
      gate             <= gate_of(psm_pkg::S_RSTW);
    end else begin
      st_q             <= st_d;
      cnt_q            <= cnt_d;
      pre_q            <= pre_d;
      t0_q             <= t0_d;
      rcdiv_q          <= rcdiv_d;
      wdc_q            <= wdc_d;
      pf_q             <= pf_d;
      pend_q           <= pend_d;
      resume_pulse     <= resume_d;
      vector_pulse     <= vector_d;
      wdt_vector_pulse <= wdtv_d;
      int_rst_q        <= int_rst_d;
      int_reset        <= int_rst_d;
      gate             <= gate_of(st_d);
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence seq_sleep_go;
    st_q == psm_pkg::S_RUN && sleep_exec && !irq_pending && !pf_fire;
  endsequence
  sequence seq_settle;
    st_q == psm_pkg::S_STAB [*8];
  endsequence

  a_sleep_ignored: assert property (st_q == psm_pkg::S_RUN && sleep_exec && irq_pending && !pf_fire
                                    |=> st_q == psm_pkg::S_RUN)
    else $error("sleep taken with irq pending");
  a_wake_entry: assert property (seq_sleep_go and ckctl_q[psm_pkg::CK_WAKE_BIT] |=> st_q == psm_pkg::S_WAKE)
    else $error("wake-timer mode not entered");
  a_rcwd_entry: assert property (seq_sleep_go and (!ckctl_q[psm_pkg::CK_WAKE_BIT] && ckctl_q[psm_pkg::CK_RCWD_BIT])
                                 |=> st_q == psm_pkg::S_RCWD)
    else $error("rc watchdog mode not entered");
  a_stop_entry: assert property (seq_sleep_go and (!ckctl_q[psm_pkg::CK_WAKE_BIT] && !ckctl_q[psm_pkg::CK_RCWD_BIT])
                                 |=> st_q == psm_pkg::S_STOP)
    else $error("stop mode not entered");
  a_wake_gating: assert property (st_q == psm_pkg::S_WAKE |-> gate.main_osc_en && gate.timer0_en && !gate.cpu_run)
    else $error("wake-timer gating wrong");
  a_rcwd_gating: assert property (st_q == psm_pkg::S_RCWD |-> !gate.main_osc_en && gate.rc_osc_en && gate.port_hold)
    else $error("rc watchdog gating wrong");
  a_wake_fast: assert property (st_q == psm_pkg::S_WAKE && ext_int && !pf_fire
                                |=> st_q == psm_pkg::S_RUN && (vector_pulse == $past(i_flag)))
    else $error("wake-timer exit not immediate");
  a_stop_settle: assert property (st_q == psm_pkg::S_STOP && ext_int && !pf_fire |=> seq_settle)
    else $error("stabilisation count skipped");
  a_wdt_reset: assert property (st_q == psm_pkg::S_RCWD && wdt_evt && ckctl_q[psm_pkg::CK_WDRST_BIT]
                                |=> int_reset ##1 st_q == psm_pkg::S_RSTW && ckctl_q == psm_pkg::CKCTL_RST)
    else $error("watchdog reset not raised");
  a_pf_reset: assert property (pf_fire |=> int_reset && st_q == psm_pkg::S_RSTW)
    else $error("power-fail reset missing");
  a_rst_wait: assert property (st_q == psm_pkg::S_RSTW && cnt_q < 24'(RST_WAIT - 1) && !pf_fire
                               |=> st_q == psm_pkg::S_RSTW)
    else $error("reset wait cut short");

endmodule : psm_ctrl
`default_nettype wire

// *** tb/psm_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module psm_cpu_model (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // Bench request
  input  wire logic               go,
  // Design side
  input  wire psm_pkg::psm_gate_s gate,
  input  wire logic               resume_pulse,
  input  wire logic               vector_pulse,
  input  wire logic               wdt_vector_pulse,
  input  wire logic               int_reset,
  output logic                    sleep_exec,
  // Event counts
  output logic [7:0]              n_res,
  output logic [7:0]              n_vec,
  output logic [7:0]              n_wdt,
  output logic [7:0]              n_rst
);
  logic [1:0] hold_q;
  // A sleep is followed by three no-ops, so no second sleep can come close behind it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sleep_exec <= 1'b0;
      hold_q     <= 2'h0;
      n_res      <= 8'h00;
      n_vec      <= 8'h00;
      n_wdt      <= 8'h00;
      n_rst      <= 8'h00;
    end else begin
      sleep_exec <= 1'b0;
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (go && gate.cpu_run) begin
        sleep_exec <= 1'b1;
        hold_q     <= 2'h3;
      end
      n_res <= n_res + 8'(resume_pulse);
      n_vec <= n_vec + 8'(vector_pulse);
      n_wdt <= n_wdt + 8'(wdt_vector_pulse);
      n_rst <= n_rst + 8'(int_reset);
    end
  end
endmodule : psm_cpu_model
`default_nettype wire

// *** tb/test_power_saving_mode_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_power_saving_mode_control;
  localparam int RW = 20;
  logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, sleep_exec, irq_pending, i_flag;
  logic resume_pulse, vector_pulse, wdt_vector_pulse, int_reset, ext_int_pin, power_fail_pin, rc_osc_pin;
  logic go, rc_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, d;
  logic [7:0] n_res, n_vec, n_wdt, n_rst, r0, v0, w0, t0, rc_div;
  psm_pkg::psm_gate_s gate;
  int n_errors, checked, tmo, i;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rstv [7] = '{32'h0, 32'h0, 32'h7F, 32'h0, 32'hFF, 32'h1, 32'h0};

  psm_ctrl #(.RST_WAIT(RW)) dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_exec(sleep_exec), .irq_pending(irq_pending), .i_flag(i_flag),
    .resume_pulse(resume_pulse), .vector_pulse(vector_pulse), .wdt_vector_pulse(wdt_vector_pulse),
    .int_reset(int_reset), .ext_int_pin(ext_int_pin), .power_fail_pin(power_fail_pin),
    .rc_osc_pin(rc_osc_pin), .gate(gate));
  psm_cpu_model cpu (.ref_clk(ref_clk), .nrst(nrst), .go(go), .gate(gate), .resume_pulse(resume_pulse),
    .vector_pulse(vector_pulse), .wdt_vector_pulse(wdt_vector_pulse), .int_reset(int_reset),
    .sleep_exec(sleep_exec), .n_res(n_res), .n_vec(n_vec), .n_wdt(n_wdt), .n_rst(n_rst));

  always #4 ref_clk = ~ref_clk;
  // RC oscillator stand-in: one rising edge every four cycles, still when not enabled
  always @(posedge ref_clk) begin
    rc_div <= rc_div + 8'h01;
    if (rc_en) rc_osc_pin <= rc_div[1];
  end
  always @(posedge ref_clk) begin
    tmo++;
    if (tmo == 60000) begin
      n_errors++;
      results();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] exp_gate(input logic [7:0] ck);
    return ck[6] ? 32'h1D : (ck[5] ? 32'h03 : 32'h01);
  endfunction : exp_gate
  function automatic int exp_stab(input logic [7:0] ck);
    return 256 << (int'(ck[2:0]) + 1);
  endfunction : exp_stab

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Whole-word single transfers; hready and read data are taken at the rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, x, exp);
  endtask : rdc
  task wait_run(input int lo, input int hi, input string nm);
    int k;
    k = 0;
    @(negedge ref_clk);
    while (gate.cpu_run !== 1'b1 && k < hi + 5) begin
      @(negedge ref_clk);
      k++;
    end
    chk(nm, 32'(k >= lo && k <= hi), 32'h1);
    @(posedge ref_clk);
  endtask : wait_run
  task snap;
    r0 = n_res;
    v0 = n_vec;
    w0 = n_wdt;
    t0 = n_rst;
  endtask : snap
  task deltas(input int er, input int ev, input int ew, input int et);
    // Event counts lag the registered pulses by one edge
    @(negedge ref_clk);
    chk("resume count", 32'(n_res - r0), er);
    chk("vector count", 32'(n_vec - v0), ev);
    chk("wdt vector count", 32'(n_wdt - w0), ew);
    chk("int reset count", 32'(n_rst - t0), et);
  endtask : deltas
  // Clock control is always written as a whole byte
  task slp(input logic [7:0] ck, input logic ifl, input logic pend);
    wr(psm_pkg::OFF_CKCTL, {24'h0, ck});
    i_flag      <= ifl;
    irq_pending <= pend;
    go          <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    if (pend) chk("refused sleep", 32'(gate.cpu_run), 32'h1);
    else chk("gate in sleep", gate, exp_gate(ck));
    @(posedge ref_clk);
    irq_pending <= 1'b0;
  endtask : slp
  task results;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    ref_clk = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    irq_pending = 0; i_flag = 0; ext_int_pin = 0; power_fail_pin = 0; rc_osc_pin = 0; rc_div = 0;
    go = 0; rc_en = 0; seed = 19; n_errors = 0; checked = 0; tmo = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk("gate after reset", gate, 32'h10);
    wait_run(RW - 2, RW + 6, "reset wait");
    for (i = 0; i < 7; i++) rdc("reset value", offs[i], rstv[i]);
    repeat (4) begin
      d = xs() & 32'h77;
      wr(psm_pkg::OFF_CKCTL, d);
      rdc("ckctl", psm_pkg::OFF_CKCTL, d);
      d = xs() & 32'h1FFFF;
      wr(psm_pkg::OFF_TIMER0_COMPARE_VALUE, d);
      rdc("timer0_compare_value", psm_pkg::OFF_TIMER0_COMPARE_VALUE, d);
      d = xs() & 32'hFF;
      wr(psm_pkg::OFF_WDTP, d);
      rdc("wdtp", psm_pkg::OFF_WDTP, d & 32'h7F);
    end
    chk("hresp", 32'(hresp), 32'h0);
    chk("hreadyout", 32'(hreadyout), 32'h1);
    $display("test done: registers");
    slp(8'h40, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      snap();
      slp(8'h40 | 8'(i << 5), i[0], 1'b0);
      ext_int_pin <= 1'b1;
      wait_run(1, 8, "wake by ext int");
      ext_int_pin <= 1'b0;
      deltas(1 - i, i, 0, 0);
    end
    for (i = 0; i < 2; i++) begin
      wr(psm_pkg::OFF_TIMER0_COMPARE_VALUE, i ? 32'h10002 : 32'h00302);
      snap();
      d = xs() & 32'h1;
      slp(8'h40, d[0], 1'b0);
      wait_run(6100, 6200, "wake by timer0");
      deltas(1 - d, d, 0, 0);
    end
    $display("test done: wake timer");
    for (i = 0; i < 2; i++) begin
      snap();
      d = xs() & 32'h1;
      slp(i ? 8'h21 : 8'h00, d[0], 1'b0);
      ext_int_pin <= 1'b1;
      wait_run(exp_stab(i ? 8'h21 : 8'h00) - 4, exp_stab(i ? 8'h21 : 8'h00) + 20, "stabilised exit");
      ext_int_pin <= 1'b0;
      deltas(1 - d, d, 0, 0);
    end
    $display("test done: stop and rc exit");
    wr(psm_pkg::OFF_WDTP, 32'h81);
    wr(psm_pkg::OFF_IRQ_ENABLE_HIGH_REG, 32'h1);
    snap();
    slp(8'h20, 1'b1, 1'b0);
    rc_en <= 1'b1;
    wait_run(2540, 2600, "wdt wake");
    rc_en <= 1'b0;
    deltas(0, 0, 1, 0);
    wr(psm_pkg::OFF_WDTP, 32'h81);
    snap();
    slp(8'h30, 1'b1, 1'b0);
    rc_en <= 1'b1;
    wait_run(2040 + RW, 2060 + RW, "wdt reset");
    rc_en <= 1'b0;
    deltas(0, 0, 0, 1);
    rdc("ckctl after int reset", psm_pkg::OFF_CKCTL, 32'h0);
    $display("test done: watchdog");
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'h3 : (i == 1) ? 32'h0 : 32'h2;
      wr(psm_pkg::OFF_PFCFG, d);
      snap();
      power_fail_pin <= 1'b1;
      repeat (i == 2 ? 4 : 12) @(posedge ref_clk);
      power_fail_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      deltas(0, 0, 0, i == 3);
    end
    wait_run(1, RW + 8, "power fail restart");
    rdc("pfcfg after reset", psm_pkg::OFF_PFCFG, 32'h0);
    $display("test done: power fail");
    results();
  end
endmodule : test_power_saving_mode_control
`default_nettype wire
